// ===== design/lmr_consts.vh
// constants for the linear regulator mask and load current measurement registers
// assumes an external serial-port engine delivers byte writes and reads by address
// Overview of operation
// - mask bit 7 set blocks regulator 1 power-good-lost flag; clear allows it.
// - mask bit 6 set blocks regulator 1 power-good-gained flag; clear allows it.
// - mask bit 4 set blocks regulator 1 current limit flag; clear allows it.
// - mask bit 3 set blocks regulator 0 power-good-lost flag; clear allows it.
// - mask bit 2 set blocks regulator 0 power-good-gained flag; clear allows it.
// - mask bit 0 set blocks regulator 0 current limit flag; clear allows it.
// - masks gate only flag setting; live status bits always follow conditions.
// - select bit 0 picks converter 0 or 1; resets to 0.
// - each host write to select register starts a new measurement.
// - in dual-phase mode, selected master reports sum of master and slave currents.
// - selected slave reports its own current only.
// - result bit 8 reads in upper register bit 0; bits 7..1 zero.
// - result weight is 20 mA per count, full scale 10.22 A.
// - lower result register holds result bits 7..0, read-only.
// - measurement completion sets ready flag unless its mask bit blocks it.
`ifndef LMR_CONSTS_VH
`define LMR_CONSTS_VH
`define LMR_OFS_MASK 8'h23
`define LMR_OFS_SEL 8'h24
`define LMR_OFS_RES_HI 8'h25
`define LMR_OFS_RES_LO 8'h26
`define LMR_BIT_L1_PGF 7
`define LMR_BIT_L1_PGR 6
`define LMR_BIT_L1_ILIM 4
`define LMR_BIT_L0_PGF 3
`define LMR_BIT_L0_PGR 2
`define LMR_BIT_L0_ILIM 0
`define LMR_MASK_USED 8'hDD
`define LMR_MASK_RST 8'h00
`define LMR_SEL_RST 8'h00
`define LMR_RES_RST 9'h000
`define LMR_LSB_MA 20
`define LMR_FULL_MA 10220
`define LMR_RES_MAX 9'h1FF
`endif

// ===== design/lmr_regs.v
// register bank: linear regulator interrupt masks and load current measurement
// assumes byte accesses arrive as one-cycle strobes from a serial-port engine,
// and an analog measurement front end that pulses done with per-phase counts
`timescale 1ns/1ps
`include "lmr_consts.vh"
module lmr_regs (
  input wire ref_clk_i,
  input wire srst_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  input wire [1:0] lin_pg_i,
  input wire [1:0] lin_curlim_i,
  input wire meas_ready_block_i,
  input wire dual_phase_i,
  input wire master_is_conv1_i,
  input wire meas_done_i,
  input wire [8:0] phase0_ma_cnt_i,
  input wire [8:0] phase1_ma_cnt_i,
  output reg [1:0] lin_pg_live_o,
  output reg [1:0] lin_curlim_live_o,
  output reg [1:0] lin_pg_event_o,
  output reg [1:0] lin_curlim_event_o,
  output reg meas_start_o,
  output reg meas_conv_sel_o,
  output reg meas_ready_event_o
);

  // address decode and write strobes
  wire hit_mask_w;
  wire hit_sel_w;
  wire hit_res_hi_w;
  wire hit_res_lo_w;
  wire wr_mask_w;
  wire wr_sel_w;

  // stored state and next values
  reg [7:0] mask_q;
  reg [7:0] mask_d;
  reg sel_q;
  reg sel_d;
  reg [8:0] result_q;
  reg [8:0] result_d;
  reg [1:0] pg_prev_q;

  // measurement arithmetic
  reg [9:0] sum_w;
  reg [8:0] res_clamp_w;
  wire meas_ready_event_d;

  // read path
  reg [7:0] res_hi_w;
  reg [7:0] res_lo_w;
  reg [7:0] sel_byte_w;
  reg [7:0] rd_d;

  // per regulator mask bits and event terms
  reg [1:0] pg_fall_blk_w;
  reg [1:0] pg_rise_blk_w;
  reg [1:0] ilim_blk_w;
  wire [1:0] pg_fall_w;
  wire [1:0] pg_rise_w;
  wire [1:0] pg_event_d;
  wire [1:0] curlim_event_d;

  assign hit_mask_w = (addr_i == `LMR_OFS_MASK);
  assign hit_sel_w = (addr_i == `LMR_OFS_SEL);
  assign hit_res_hi_w = (addr_i == `LMR_OFS_RES_HI);
  assign hit_res_lo_w = (addr_i == `LMR_OFS_RES_LO);

  // result registers ignore writes; only mask and select take data
  assign wr_mask_w = wr_en_i & hit_mask_w;
  assign wr_sel_w = wr_en_i & hit_sel_w;

  // mask register: reserved bits 5 and 1 never store a one
  always @* begin
    mask_d = mask_q;
    if (wr_mask_w) begin
      mask_d = wdata_i & `LMR_MASK_USED;
    end
  end

  // select register: only bit 0 is kept
  always @* begin
    sel_d = sel_q;
    if (wr_sel_w) begin
      sel_d = wdata_i[0];
    end
  end

  // dual-phase master sums both phases; slave or single-phase converter reports itself
  always @* begin
    if (dual_phase_i && (sel_q == master_is_conv1_i)) begin
      sum_w = {1'b0, phase0_ma_cnt_i} + {1'b0, phase1_ma_cnt_i};
    end else if (sel_q) begin
      sum_w = {1'b0, phase1_ma_cnt_i};
    end else begin
      sum_w = {1'b0, phase0_ma_cnt_i};
    end
  end

  // each count is 20 mA; a sum past 511 counts is held at 10.22 A
  always @* begin
    if (sum_w[9]) begin
      res_clamp_w = `LMR_RES_MAX;
    end else begin
      res_clamp_w = sum_w[8:0];
    end
  end

  // result only moves when the front end reports a finished measurement
  always @* begin
    result_d = result_q;
    if (meas_done_i) begin
      result_d = res_clamp_w;
    end
  end

  assign meas_ready_event_d = meas_done_i & ~meas_ready_block_i;

  // result halves as the host sees them; no latching between the two reads
  always @* begin
    res_hi_w = {7'h00, result_q[8]};
    res_lo_w = result_q[7:0];
    sel_byte_w = {7'h00, sel_q};
  end

  // read mux; reserved bits and unmapped addresses read zero
  always @* begin
    rd_d = 8'h00;
    if (hit_mask_w) begin
      rd_d = mask_q;
    end
    if (hit_sel_w) begin
      rd_d = sel_byte_w;
    end
    if (hit_res_hi_w) begin
      rd_d = res_hi_w;
    end
    if (hit_res_lo_w) begin
      rd_d = res_lo_w;
    end
  end

  // mask bit picks per regulator
  always @* begin
    pg_fall_blk_w[0] = mask_q[`LMR_BIT_L0_PGF];
    pg_fall_blk_w[1] = mask_q[`LMR_BIT_L1_PGF];
    pg_rise_blk_w[0] = mask_q[`LMR_BIT_L0_PGR];
    pg_rise_blk_w[1] = mask_q[`LMR_BIT_L1_PGR];
    ilim_blk_w[0] = mask_q[`LMR_BIT_L0_ILIM];
    ilim_blk_w[1] = mask_q[`LMR_BIT_L1_ILIM];
  end

  // per regulator edge detect; masks gate the flag pulses only
  // current limit is a level, so an unmasked limit pulses every cycle it lasts
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lin
      assign pg_rise_w[g] = ~pg_prev_q[g] & lin_pg_i[g];
      assign pg_fall_w[g] = pg_prev_q[g] & ~lin_pg_i[g];
      assign pg_event_d[g] = (pg_rise_w[g] & ~pg_rise_blk_w[g])
                           | (pg_fall_w[g] & ~pg_fall_blk_w[g]);
      assign curlim_event_d[g] = lin_curlim_i[g] & ~ilim_blk_w[g];
    end
  endgenerate

  // register bank state
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      mask_q <= `LMR_MASK_RST;
      sel_q <= 1'b0;
      result_q <= `LMR_RES_RST;
    end else begin
      mask_q <= mask_d;
      sel_q <= sel_d;
      result_q <= result_d;
    end
  end

  // measurement control outputs, one-cycle pulses except the select copy
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      meas_start_o <= 1'b0;
      meas_conv_sel_o <= 1'b0;
      meas_ready_event_o <= 1'b0;
    end else begin
      meas_start_o <= wr_sel_w;
      meas_conv_sel_o <= sel_d;
      meas_ready_event_o <= meas_ready_event_d;
    end
  end

  // read data holds between reads; a read and write together return the old value
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_en_i) begin
      rdata_o <= rd_d;
    end
  end

  // edge history starts low, so power-good high straight after reset
  // reports a rise unless that rise is masked
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      pg_prev_q <= 2'h0;
    end else begin
      pg_prev_q <= lin_pg_i;
    end
  end

  // live status follows the pins whatever the masks say
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      lin_pg_live_o <= 2'h0;
      lin_curlim_live_o <= 2'h0;
    end else begin
      lin_pg_live_o <= lin_pg_i;
      lin_curlim_live_o <= lin_curlim_i;
    end
  end

  // flag pulses to the flag register outside this block
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      lin_pg_event_o <= 2'h0;
      lin_curlim_event_o <= 2'h0;
    end else begin
      lin_pg_event_o <= pg_event_d;
      lin_curlim_event_o <= curlim_event_d;
    end
  end

endmodule // lmr_regs

// ===== verification/lmr_regs_monitor.sv
// port checker for lmr_regs
// assumes a bind by port name
`timescale 1ns/1ps
module lmr_regs_monitor (
  input wire ref_clk_i,
  input wire srst_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire meas_done_i,
  input wire meas_ready_block_i,
  input wire meas_start_o,
  input wire meas_ready_event_o,
  input wire [7:0] addr_i,
  input wire [7:0] rdata_o,
  input wire [1:0] lin_pg_i,
  input wire [1:0] lin_pg_live_o,
  input wire [1:0] lin_pg_event_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence sel_write_s;
    wr_en_i && addr_i == 8'h24;
  endsequence
  start_after_sel_a: assert property (sel_write_s |=> meas_start_o)
    else $error("no start after select write");
  pg_live_a: assert property (!$past(srst_i) |-> lin_pg_live_o == $past(lin_pg_i))
    else $error("live");
  start_pulse_a: assert property (!$past(srst_i) |->
    meas_start_o == $past(wr_en_i && addr_i == 8'h24)) else $error("start");
  ready_pulse_a: assert property (!$past(srst_i) |->
    meas_ready_event_o == $past(meas_done_i && !meas_ready_block_i)) else $error("ready");
  hi_zero_a: assert property (rd_en_i && addr_i == 8'h25 |=> rdata_o[7:1] == 7'h00)
    else $error("upper");
  unmapped_zero_a: assert property (rd_en_i && addr_i > 8'h26 |=> rdata_o == 8'h00)
    else $error("unmapped");
  // an event without a live change means the edge detect is broken
  pg_event_a: assert property (2'h0 == (lin_pg_event_o
    & ~(lin_pg_live_o ^ $past(lin_pg_live_o)))) else $error("pg event");
endmodule // lmr_regs_monitor
bind lmr_regs lmr_regs_monitor u_mon (.*);

// ===== verification/lmr_front_model.sv
// measurement front end model
// assumes one start pulse per measurement
`timescale 1ns/1ps
module lmr_front_model (input wire ref_clk_i, meas_start_o, output reg meas_done_i = 1'h0,
  output wire [8:0] phase0_ma_cnt_i, phase1_ma_cnt_i);
  reg [1:0] d_q = 2'h0;
  // counts are junk outside done
  assign phase0_ma_cnt_i = meas_done_i ? 9'h0C8 : 9'h137;
  assign phase1_ma_cnt_i = meas_done_i ? 9'h150 : 9'h0AF;
  always @(posedge ref_clk_i) begin
    d_q <= {d_q[0], meas_start_o};
    meas_done_i <= d_q[1];
  end
endmodule // lmr_front_model

// ===== verification/test_lmr_regs.sv
// bench: registers, masks, measurements of lmr_regs
// assumes lmr_front_model as front end
`timescale 1ns/1ps
module test_lmr_regs;
  reg ref_clk_i = 1'h0, srst_i = 1'h1, wr_en_i = 1'h0, rd_en_i = 1'h0, meas_ready_block_i = 1'h0;
  reg dual_phase_i = 1'h0, master_is_conv1_i = 1'h1;
  reg [7:0] addr_i = 8'h00, wdata_i = 8'h00, mv;
  reg [1:0] lin_pg_i = 2'h0, lin_curlim_i = 2'h0;
  reg [4:0] ev = 5'h00;
  reg [8:0] ex;
  wire [7:0] rdata_o;
  wire [1:0] lin_pg_live_o, lin_curlim_live_o, lin_pg_event_o, lin_curlim_event_o;
  wire meas_start_o, meas_conv_sel_o, meas_ready_event_o, meas_done_i;
  wire [8:0] phase0_ma_cnt_i, phase1_ma_cnt_i;
  integer miscompares = 0, n_compared = 0, cyc = 0, i;
  lmr_regs DUT (.*);
  lmr_front_model FE (.*);
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    ev <= ev | {meas_ready_event_o, lin_pg_event_o, lin_curlim_event_o};
    cyc <= cyc + 1;
    if (cyc == 3000) begin miscompares = miscompares + 1; report_and_stop; end
  end
  task report_and_stop;
    begin $display("compared %0d bad %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish; end
  endtask
  task chk(input [8:0] s, e);
    begin n_compared = n_compared + 1;
      if (s !== e) begin miscompares = miscompares + 1; $display("BAD %0t %h not %h", $time, s, e); end
    end
  endtask
  task wr(input [7:0] a, d);
    begin @(posedge ref_clk_i) wr_en_i <= 1'h1; addr_i <= a; wdata_i <= d;
      @(posedge ref_clk_i) wr_en_i <= 1'h0; #1; end
  endtask
  task rd(input [7:0] a, input [8:0] e);
    begin @(posedge ref_clk_i) rd_en_i <= 1'h1; addr_i <= a;
      @(posedge ref_clk_i) rd_en_i <= 1'h0; @(posedge ref_clk_i) #1 chk(rdata_o, e); end
  endtask
  task step; begin repeat (3) @(posedge ref_clk_i); #1; end endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    for (i = 0; i < 5; i = i + 1) rd(8'h22 + i[7:0], 9'h000);
    wr(8'h23, 8'hFF); rd(8'h23, 9'h0DD);
    wr(8'h25, 8'hFF); wr(8'h24, 8'hFE); rd(8'h24, 9'h000);
    rd(8'h25, 9'h000); $display("test regs done");
    // mask 8'h22 only touches reserved bits, so every event must still come
    for (i = 0; i < 4; i = i + 1) begin
      mv = 8'h11 << i; wr(8'h23, mv); ev = 5'h00;
      @(posedge ref_clk_i) lin_pg_i <= 2'h3; lin_curlim_i <= 2'h3; step;
      chk(ev[3:0], {5'h00, ~{mv[6], mv[2], mv[4], mv[0]}});
      chk({lin_pg_live_o, lin_curlim_live_o}, 4'hF);
      ev = 5'h00; @(posedge ref_clk_i) lin_pg_i <= 2'h0; lin_curlim_i <= 2'h0; step;
      chk(ev[3:2], {7'h00, ~{mv[7], mv[3]}});
    end
    $display("test mask done");
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge ref_clk_i) dual_phase_i <= i[1]; meas_ready_block_i <= i == 3;
      wr(8'h24, {7'h00, i[0] ^ i[1]}); ev = 5'h00; step; step; step;
      ex = i == 1 ? 9'h150 : i == 2 ? 9'h1FF : 9'h0C8;
      chk(ev[4], i != 3);
      chk(meas_conv_sel_o, i[0] ^ i[1]);
      rd(8'h26, {1'h0, ex[7:0]});
      rd(8'h25, {8'h00, ex[8]});
    end
    $display("test meas done");
    report_and_stop;
  end
endmodule // test_lmr_regs
